// File: src/vss_map.svh
`ifndef VSS_MAP_SVH
`define VSS_MAP_SVH

// Register byte offsets
`define VSS_OFF_CTRL      12'h000
`define VSS_OFF_RATE      12'h004
`define VSS_OFF_STATUS    12'h008
`define VSS_OFF_VID       12'h00C

// Field positions and reset values
`define VSS_CTRL_MODE_LSB 0
`define VSS_CTRL_RST      2'h0
`define VSS_RATE_RST      10'h064
`define VSS_ST_REF_LSB    8
`define VSS_ST_PG_BIT     24
`define VSS_ST_DRV_BIT    25

// Levels in 6.25mV steps
`define VSS_BOOT_LEVEL    9'h0B0
`define VSS_NOLOAD_CODE   5'h1F

// Timing
`define VSS_CLK_KHZ       40000
`define VSS_T_INIT_NS     1100000
`define VSS_T_HOLD_NS     93000
`define VSS_T_PGD_NS      93000
`define VSS_T_ZERO_I_NS   35
`define VSS_T_BLANK_NS    20
`define VSS_STEP_NS_KOHM  50
`define VSS_VID_CLK_KHZ   5500
`define VSS_VID_SAMPLES   3
`define VSS_CYC_MIN(ns)   (((ns) * (`VSS_CLK_KHZ / 1000) + 999) / 1000)

`endif

// File: src/vss_pkg.sv
package vss_pkg;

    typedef enum logic [6:0] {
        SQ_SHUT       = 7'b0000001,
        SQ_INIT       = 7'b0000010,
        SQ_RAMP_BOOT  = 7'b0000100,
        SQ_BOOT_HOLD  = 7'b0001000,
        SQ_RAMP_FINAL = 7'b0010000,
        SQ_PG_DELAY   = 7'b0100000,
        SQ_RUN        = 7'b1000000
    } vss_seq_t;

    typedef enum logic [4:0] {
        DT_OFF     = 5'b00001,
        DT_LS_ON   = 5'b00010,
        DT_LS_FALL = 5'b00100,
        DT_HS_ON   = 5'b01000,
        DT_HS_FALL = 5'b10000
    } vss_dt_t;

    typedef enum logic [1:0] {
        MODE_VR   = 2'h0,
        MODE_AMD5 = 2'h1,
        MODE_AMD6 = 2'h2
    } vss_mode_t;

endpackage

// File: src/vss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vss_map.svh"

module vss_top #(
    parameter int INIT_CYCLES = `VSS_CYC_MIN(`VSS_T_INIT_NS)
) (
    // Clock and reset
    input  wire logic             CLOCK,
    input  wire logic             RESETN,
    // APB slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // Supply, enable and feedback comparators
    input  wire logic             BIAS_POR_OK,
    input  wire logic             DRIVER_SUPPLY_POR_OK,
    input  wire logic             ENABLE_ABOVE,
    input  wire logic             FEEDBACK_NODE_ABOVE_REF,
    input  wire logic             SENSED_OUTPUT_IN_WINDOW,
    // Voltage identification from processor and table decoder
    input  wire logic [7:0]       VOLTAGE_ID_CODE,
    input  wire logic [8:0]       VOLTAGE_ID_LEVEL,
    // Switching stage
    input  wire logic             PWM,
    input  wire logic             SW_NODE_AT_THRESH,
    input  wire logic             LOW_GATE_BELOW,
    input  wire logic             HIGH_GATE_NEAR_SW,
    input  wire logic             SW_NODE_BELOW,
    output logic                  HIGH_SIDE_GATE,
    output logic                  LOW_SIDE_GATE,
    // Sequencer outputs
    output logic      [8:0]       REF_DAC,
    output logic                  POWER_GOOD,
    output logic                  DRIVERS_ON
);
    import vss_pkg::*;

    localparam int HOLD_CYCLES  = `VSS_CYC_MIN(`VSS_T_HOLD_NS);
    localparam int PGD_CYCLES   = `VSS_CYC_MIN(`VSS_T_PGD_NS);
    localparam int ZERO_I_CYC   = `VSS_CYC_MIN(`VSS_T_ZERO_I_NS);
    localparam int BLANK_CYC    = `VSS_CYC_MIN(`VSS_T_BLANK_NS);
    localparam int STEP_PER_K   = `VSS_CYC_MIN(`VSS_STEP_NS_KOHM);
    localparam int VID_DIV      = `VSS_CLK_KHZ / `VSS_VID_CLK_KHZ;
    localparam int NCOMP        = 9;

    logic [NCOMP-1:0] comp_raw;
    logic [NCOMP-1:0] comp_meta;
    logic [NCOMP-1:0] comp_s;
    logic             bias_ok;
    logic             drv_ok;
    logic             en_ok;
    logic             fb_above;
    logic             in_window;
    logic             sw_at;
    logic             lsg_below;
    logic             hsg_near;
    logic             sw_below;
    vss_mode_t        mode;
    logic [9:0]       rate_kohm;
    vss_seq_t         seq;
    vss_dt_t          dt;
    logic [15:0]      dly_cnt;
    logic [8:0]       target;
    logic [11:0]      step_cnt;
    logic             ss_tick;
    logic             ramping;
    logic [2:0]       vid_div_cnt;
    logic             vid_tick;
    logic [7:0]       vid_s1;
    logic [7:0]       vid_s2;
    logic [7:0]       vid_stable;
    logic [8:0]       lvl_stable;
    logic             qual;
    logic             start_ok;
    logic             is_amd;
    logic             drv_latch;
    logic [1:0]       blank_cnt;
    logic [1:0]       zi_cnt;
    logic             release_hs;
    logic             apb_wr;
    logic             apb_setup;
    logic             addr_ok;

    // Comparators are asynchronous to the clock, so each passes two flops
    assign comp_raw = {BIAS_POR_OK, DRIVER_SUPPLY_POR_OK, ENABLE_ABOVE,
                       FEEDBACK_NODE_ABOVE_REF, SENSED_OUTPUT_IN_WINDOW,
                       SW_NODE_AT_THRESH, LOW_GATE_BELOW, HIGH_GATE_NEAR_SW,
                       SW_NODE_BELOW};
    genvar gi;
    generate
        for (gi = 0; gi < NCOMP; gi++) begin : g_sync
            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    comp_meta[gi] <= 1'b0;
                    comp_s[gi]    <= 1'b0;
                end else begin
                    comp_meta[gi] <= comp_raw[gi];
                    comp_s[gi]    <= comp_meta[gi];
                end
            end
        end
    endgenerate
    assign {bias_ok, drv_ok, en_ok, fb_above, in_window,
            sw_at, lsg_below, hsg_near, sw_below} = comp_s;

    // Start qualifiers; enable hysteresis lives in the analog comparator
    assign is_amd   = (mode == MODE_AMD5) || (mode == MODE_AMD6);
    assign qual     = bias_ok && drv_ok && en_ok;
    assign start_ok = qual && !((mode == MODE_AMD5) &&
                      (vid_stable[4:0] == `VSS_NOLOAD_CODE));

    // Sampling clock for code validation, CLOCK divided by 7 (about 5.7MHz) as an enable pulse
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            vid_div_cnt <= 3'h0;
        end else if (vid_div_cnt == 3'(VID_DIV - 1)) begin
            vid_div_cnt <= 3'h0;
        end else begin
            vid_div_cnt <= vid_div_cnt + 3'h1;
        end
    end
    assign vid_tick = (vid_div_cnt == 3'h0);

    // A code counts only after three identical consecutive samples
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            vid_s1     <= 8'h00;
            vid_s2     <= 8'h00;
            vid_stable <= 8'h00;
            lvl_stable <= 9'h000;
        end else if (vid_tick) begin
            vid_s1 <= VOLTAGE_ID_CODE;
            vid_s2 <= vid_s1;
            if (VOLTAGE_ID_CODE == vid_s1 && vid_s1 == vid_s2) begin
                vid_stable <= VOLTAGE_ID_CODE;
                lvl_stable <= VOLTAGE_ID_LEVEL;
            end
        end
    end

    // Soft-start oscillator: one step per rate_kohm * 50ns
    assign ramping = (seq == SQ_RAMP_BOOT) || (seq == SQ_RAMP_FINAL);
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            step_cnt <= 12'h000;
        end else if (!ramping || ss_tick) begin
            step_cnt <= 12'(rate_kohm * STEP_PER_K);
        end else begin
            step_cnt <= step_cnt - 12'h001;
        end
    end
    assign ss_tick = ramping && (step_cnt <= 12'h001);

    // Soft-start sequencer
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            seq     <= SQ_SHUT;
            dly_cnt <= 16'h0000;
            target  <= 9'h000;
            REF_DAC <= 9'h000;
        end else if (!qual) begin
            seq     <= SQ_SHUT;
            dly_cnt <= 16'h0000;
            REF_DAC <= 9'h000;
        end else begin
            case (seq)
                SQ_SHUT: begin
                    REF_DAC <= 9'h000;
                    dly_cnt <= 16'h0000;
                    if (start_ok) begin
                        seq    <= SQ_INIT;
                        target <= is_amd ? lvl_stable : `VSS_BOOT_LEVEL;
                    end
                end
                SQ_INIT: begin
                    dly_cnt <= dly_cnt + 16'h0001;
                    if (dly_cnt == 16'(INIT_CYCLES - 1)) begin
                        dly_cnt <= 16'h0000;
                        seq     <= is_amd ? SQ_RAMP_FINAL : SQ_RAMP_BOOT;
                    end
                end
                SQ_RAMP_BOOT, SQ_RAMP_FINAL: begin
                    if (REF_DAC == target) begin
                        dly_cnt <= 16'h0000;
                        if (seq == SQ_RAMP_BOOT) begin
                            seq <= SQ_BOOT_HOLD;
                        end else begin
                            seq <= is_amd ? SQ_RUN : SQ_PG_DELAY;
                        end
                    end else if (ss_tick) begin
                        // One 6.25mV step either way
                        if (REF_DAC < target) begin
                            REF_DAC <= REF_DAC + 9'h001;
                        end else begin
                            REF_DAC <= REF_DAC - 9'h001;
                        end
                    end
                end
                SQ_BOOT_HOLD: begin
                    // An invalid code keeps the boot level and is re-checked
                    if (dly_cnt == 16'(HOLD_CYCLES - 1)) begin
                        if (lvl_stable != 9'h000) begin
                            target <= lvl_stable;
                            seq    <= SQ_RAMP_FINAL;
                            dly_cnt <= 16'h0000;
                        end
                    end else begin
                        dly_cnt <= dly_cnt + 16'h0001;
                    end
                end
                SQ_PG_DELAY: begin
                    dly_cnt <= dly_cnt + 16'h0001;
                    if (dly_cnt == 16'(PGD_CYCLES - 1)) begin
                        seq <= SQ_RUN;
                    end
                end
                SQ_RUN: begin
                    seq <= SQ_RUN;
                end
                default: begin
                    seq <= SQ_SHUT;
                end
            endcase
        end
    end

    // Pre-biased start: drivers stay off until reference passes feedback
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            drv_latch <= 1'b0;
        end else if (seq == SQ_SHUT || seq == SQ_INIT) begin
            drv_latch <= 1'b0;
        end else if (!fb_above) begin
            drv_latch <= 1'b1;
        end
    end

    // Soft-start end enables drivers regardless of a high pre-charge
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            DRIVERS_ON <= 1'b0;
            POWER_GOOD <= 1'b0;
        end else begin
            DRIVERS_ON <= qual && (drv_latch || seq == SQ_PG_DELAY ||
                          seq == SQ_RUN);
            if (is_amd) begin
                POWER_GOOD <= qual && (seq == SQ_RUN) && in_window;
            end else begin
                POWER_GOOD <= qual && (seq == SQ_RUN);
            end
        end
    end

    // High gate release: switch node after blanking, or zero-current timeout
    assign release_hs = ((blank_cnt == 2'h0) && sw_at) ||
                        (zi_cnt == 2'(ZERO_I_CYC));

    // Dead-time hand-off between the two gates
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            dt        <= DT_OFF;
            blank_cnt <= 2'h0;
            zi_cnt    <= 2'h0;
        end else if (!DRIVERS_ON) begin
            dt <= DT_OFF;
        end else begin
            case (dt)
                DT_OFF: begin
                    dt <= DT_HS_FALL;
                end
                DT_LS_ON: begin
                    if (PWM) begin
                        dt        <= DT_LS_FALL;
                        blank_cnt <= 2'(BLANK_CYC);
                        zi_cnt    <= 2'h0;
                    end
                end
                DT_LS_FALL: begin
                    if (blank_cnt != 2'h0) begin
                        blank_cnt <= blank_cnt - 2'h1;
                    end
                    if (lsg_below && zi_cnt != 2'(ZERO_I_CYC)) begin
                        zi_cnt <= zi_cnt + 2'h1;
                    end
                    if (!PWM) begin
                        dt <= DT_HS_FALL;
                    end else if (release_hs) begin
                        dt <= DT_HS_ON;
                    end
                end
                DT_HS_ON: begin
                    if (!PWM) begin
                        dt <= DT_HS_FALL;
                    end
                end
                DT_HS_FALL: begin
                    if (hsg_near || sw_below) begin
                        dt <= DT_LS_ON;
                    end
                end
                default: begin
                    dt <= DT_OFF;
                end
            endcase
        end
    end
    assign HIGH_SIDE_GATE = (dt == DT_HS_ON);
    assign LOW_SIDE_GATE  = (dt == DT_LS_ON);

    // APB slave: zero wait states, read data captured in the setup cycle
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign addr_ok   = (PADDR == `VSS_OFF_CTRL) || (PADDR == `VSS_OFF_RATE) ||
                       (PADDR == `VSS_OFF_STATUS) || (PADDR == `VSS_OFF_VID);
    assign PREADY    = 1'b1;
    assign PSLVERR   = PSEL && PENABLE && !addr_ok;

    // Control registers; mode takes effect at once, also in the middle of a sequence
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            mode      <= vss_mode_t'(`VSS_CTRL_RST);
            rate_kohm <= `VSS_RATE_RST;
        end else if (apb_wr && PADDR == `VSS_OFF_CTRL) begin
            mode <= vss_mode_t'(PWDATA[`VSS_CTRL_MODE_LSB +: 2]);
        end else if (apb_wr && PADDR == `VSS_OFF_RATE) begin
            rate_kohm <= PWDATA[9:0];
        end
    end

    // Read mux
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0000_0000;
        end else if (apb_setup) begin
            case (PADDR)
                `VSS_OFF_CTRL:   PRDATA <= {30'h0, mode};
                `VSS_OFF_RATE:   PRDATA <= {22'h0, rate_kohm};
                `VSS_OFF_STATUS: PRDATA <= {6'h0, DRIVERS_ON, POWER_GOOD, 7'h00,
                                            REF_DAC, 1'b0, seq};
                `VSS_OFF_VID:    PRDATA <= {15'h0, lvl_stable, vid_stable};
                default:         PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    chk_shut_gates: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (seq == SQ_SHUT) |=> !HIGH_SIDE_GATE && !LOW_SIDE_GATE)
        else $error("gate driven in shutdown");
    chk_qual_drop: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !qual |=> (seq == SQ_SHUT) ##1 !DRIVERS_ON)
        else $error("no shutdown after qualifier loss");
    chk_noload_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (seq == SQ_SHUT && mode == MODE_AMD5 &&
         vid_stable[4:0] == `VSS_NOLOAD_CODE) |=> (seq == SQ_SHUT))
        else $error("started on no-load code");
    chk_start_now: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (seq == SQ_SHUT && qual && mode != MODE_AMD5) |=> (seq == SQ_INIT))
        else $error("soft-start not begun");
    chk_hs_release: assert property (@(posedge CLOCK) disable iff (!RESETN)
        $rose(HIGH_SIDE_GATE) |-> $past(dt) == DT_LS_FALL && $past(release_hs)
        && $past(blank_cnt == 2'h0 && sw_at || zi_cnt == 2'(ZERO_I_CYC)))
        else $error("high gate released early");
    chk_blanking: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (dt == DT_LS_ON && PWM && DRIVERS_ON) |=> !HIGH_SIDE_GATE ##1
        !HIGH_SIDE_GATE)
        else $error("blanking skipped");
    chk_ls_release: assert property (@(posedge CLOCK) disable iff (!RESETN)
        $rose(LOW_SIDE_GATE) |-> $past(dt) == DT_HS_FALL &&
        $past(hsg_near || sw_below))
        else $error("low gate released early");
    chk_ref_step: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (ramping && qual && $changed(REF_DAC)) |-> (REF_DAC == $past(REF_DAC) + 9'h001
        || REF_DAC == $past(REF_DAC) - 9'h001))
        else $error("reference step not one code");
    chk_pg_window: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (seq == SQ_RUN && is_amd && qual) ##1 (seq == SQ_RUN) |->
        POWER_GOOD == $past(in_window))
        else $error("power good ignores window");
    chk_prebias: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (ramping && fb_above && !drv_latch) |=> !DRIVERS_ON ##1
        !HIGH_SIDE_GATE && !LOW_SIDE_GATE)
        else $error("drivers on above reference");

endmodule
`default_nettype wire

// File: verification/vss_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// Power stage: gate levels follow the gate commands LAG clocks late, switch node levels LAG+1 clocks late
module vss_stage_model #(
    parameter int LAG = 2
) (
    input  wire logic clk,
    input  wire logic zero_i,
    input  wire logic high_gate,
    input  wire logic low_gate,
    output logic      low_gate_below,
    output logic      high_gate_near_sw,
    output logic      sw_node_below,
    output logic      sw_at_thresh
);
    logic [7:0] hs_hist = 8'h00;
    logic [7:0] ls_hist = 8'h00;
    // Gate charge history; a real gate never empties in the cycle it is released
    always_ff @(posedge clk) begin
        hs_hist <= {hs_hist[6:0], high_gate};
        ls_hist <= {ls_hist[6:0], low_gate};
    end
    assign low_gate_below    = !ls_hist[LAG-1];
    // With no inductor current the node never reaches its threshold
    assign sw_at_thresh      = !zero_i && !ls_hist[LAG];
    assign high_gate_near_sw = !hs_hist[LAG-1];
    assign sw_node_below     = !hs_hist[LAG];
endmodule
`default_nettype wire

// File: verification/vss_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vss_top_bench;
    import vss_pkg::*;
    localparam int INIT = 50;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, zero = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        bias = 0, drv = 0, en = 0, fba = 0, win = 1, pwm = 0;
    logic [7:0]  code = 8'h00;
    logic [8:0]  level = 9'h000, ref_dac;
    logic        pready, err, lgb, hgn, swb, swt, hsg, lsg, pg, drv_on;
    logic        slverr = 0;
    logic [3:0]  obs;
    int          miscompares = 0, n_compared = 0, n;
    assign obs = {drv_on, lsg, hsg, pg};

    initial forever #12.5 clk = ~clk;

    vss_top #(.INIT_CYCLES(INIT)) vss_top_i (.CLOCK(clk), .RESETN(rstn), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(err), .BIAS_POR_OK(bias), .DRIVER_SUPPLY_POR_OK(drv),
        .ENABLE_ABOVE(en), .FEEDBACK_NODE_ABOVE_REF(fba), .SENSED_OUTPUT_IN_WINDOW(win),
        .VOLTAGE_ID_CODE(code), .VOLTAGE_ID_LEVEL(level), .PWM(pwm), .SW_NODE_AT_THRESH(swt),
        .LOW_GATE_BELOW(lgb), .HIGH_GATE_NEAR_SW(hgn), .SW_NODE_BELOW(swb),
        .HIGH_SIDE_GATE(hsg), .LOW_SIDE_GATE(lsg), .REF_DAC(ref_dac), .POWER_GOOD(pg),
        .DRIVERS_ON(drv_on));
    vss_stage_model #(.LAG(2)) vss_stage_model_i (.clk(clk), .zero_i(zero), .high_gate(hsg),
        .low_gate(lsg), .low_gate_below(lgb), .high_gate_near_sw(hgn), .sw_node_below(swb),
        .sw_at_thresh(swt));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Measured cycle counts only need to land inside a window
    task chk_span(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk) pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slverr = err;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    // Count cycles until the reference equals (eq=1) or leaves (eq=0) a value
    task wait_ref(input logic [8:0] v, input logic eq);
        n = 0;
        while ((ref_dac === v) != eq && n < 20000) begin @(posedge clk); n++; end
    endtask
    task wait_bit(input int s, input logic v);
        n = 0;
        while (obs[s] !== v && n < 5000) begin @(posedge clk); n++; end
    endtask
    task qual(input logic b, input logic d, input logic e);
        bias <= b; drv <= d; en <= e;
        @(posedge clk);
    endtask

    task t_regs;
        apb(0, 12'h004, 0); chk(rd, 32'h64);
        apb(0, 12'h008, 0); chk({25'h0, rd[6:0]}, {25'h0, SQ_SHUT});
        chk({hsg, lsg}, 0);
        apb(1, 12'h010, 32'h5); chk(slverr, 1);
        apb(1, 12'h004, 32'h1); apb(0, 12'h004, 0); chk(rd, 32'h1);
        $display("test regs done");
    endtask
    task t_vr;
        code <= 8'h3A; level <= 9'h0A0; // code settled long before the hold ends
        qual(1, 1, 1);
        wait_ref(0, 0); chk_span(n, INIT, INIT + 8);
        wait_ref(9'h0B0, 1); chk_span(n, 348, 352);
        chk(drv_on, 1);
        wait_ref(9'h0B0, 0); chk_span(n, 3720, 3730);
        wait_ref(9'h0A0, 1); chk_span(n, 28, 32);
        chk(pg, 0);
        wait_bit(0, 1); chk_span(n, 3720, 3724);
        $display("test vr done");
    endtask
    // Gate hand-off with and without inductor current
    task t_dead;
        for (int z = 0; z < 2; z++) begin
            zero <= z[0];
            pwm <= 1; wait_bit(1, 1); chk_span(n, 1, 12);
            pwm <= 0; wait_bit(2, 1); chk_span(n, 1, 12);
        end
        $display("test dead done");
    endtask
    task t_shut;
        qual(1, 0, 1);
        wait_ref(0, 1); chk_span(n, 0, 5);
        @(posedge clk); chk({hsg, lsg, pg}, 0);
        qual(1, 1, 0);
        repeat (100) @(posedge clk);
        chk(ref_dac, 0);
        $display("test shut done");
    endtask
    task t_amd(input logic [1:0] m);
        code <= 8'h1F; level <= 9'h060; fba <= 1;
        qual(1, 1, 0); apb(1, 12'h000, {30'h0, m});
        // Let the no-load code pass validation before enabling
        repeat (30) @(posedge clk);
        qual(1, 1, 1);
        if (m == 2'h1) begin
            repeat (200) @(posedge clk);
            chk(ref_dac, 0);
            code <= 8'h05;
        end
        wait_ref(0, 0); chk_span(n, INIT, INIT + 30);
        wait_ref(9'h060, 1); chk_span(n, 188, 192);
        chk(drv_on, 0);
        wait_bit(3, 1); chk_span(n, 0, 4);
        wait_bit(0, 1); chk_span(n, 0, 4);
        $display("test amd done");
    endtask

    task final_report;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        t_regs; t_vr; t_dead; t_shut; t_amd(2'h1); t_amd(2'h2);
        final_report;
    end
    // Whole run needs about 9000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire
